// ==== core/alu_params.svh ====
// Purpose: constants for the microcore slew, status-bit and subtraction group
// Assumes: one instruction per sys_clk cycle while instr_valid_i is high
// Notes: multi-bit field slices are written as part-select ranges, single-bit fields as bit indexes
//
// Functional notes
// RULE_01: slew operand 0 selects programmed slew, 1 forces highest slew rate.
// RULE_02: slew change applies only when this microcore holds output drive right.
// RULE_03: after reset the slew mode is normal, not forced fast.
// RULE_04: slow to fast becomes effective one cycle after the instruction.
// RULE_05: fast to slow becomes effective four cycles after the instruction.
// RULE_06: slew word is fixed opcode in bits 15..1, mode in bit 0.
// RULE_07: status-bit op writes one level into the status bit picked by index.
// RULE_08: status-bit word: level in bit 4, index in bits 3..0.
// RULE_09: register subtract writes first source minus second source to destination.
// RULE_10: both subtractions update zero, negative, and four wrap flags.
// RULE_11: register subtract word: 001010 on top, then dest, second, first source.
// RULE_12: immediate subtract takes a 4-bit constant from a source register.
// RULE_13: immediate subtract word: 000111, dest, 4-bit constant, source.
// RULE_14: byte swap exchanges low and high bytes of the selected register.
// RULE_15: byte swap word: opcode in bits 15..3, register in bits 2..0.
// RULE_16: with sign flag clear, conversion clears the register msb.
// RULE_17: with sign flag set, low fifteen bits negated and msb set.
// RULE_18: conversion word: opcode in upper bits, register in bits 2..0.
// RULE_19: sign flag keeps the sign of the latest reverse conversion.
// RULE_20: selects are 3-bit indexes; results land at end of execute cycle.
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define DATA_W        16
`define SEL_W         3
`define NREG          8
`define CFG_AW        9

`define GRANT_A_ADDR  9'h184
`define GRANT_B_ADDR  9'h185
`define GRANT_C_ADDR  9'h186
`define GRANT_D_ADDR  9'h187
// bits of the grant registers that belong to this microcore
`define GRANT_MASK    16'h0001

`define OPC_SUBI      6'h07
`define OPC_SUB       6'h0a
`define OPC_SWAP      13'h06ac
`define OPC_MAGNITUDE_TO_TWOS_FORM_OP      13'h06e6
`define OPC_SLEW      15'h1acb
`define OPC_SRB       11'h1b8

`define F_OPC6        15:10
`define F_OPC11       15:5
`define F_OPC13       15:3
`define F_OPC15       15:1
`define F_OP1         2:0
`define F_OP2         5:3
`define F_RES_SUB     8:6
`define F_RES_SUBI    9:7
`define F_IMM         6:3
`define F_SRB_IDX     3:0
`define F_SRB_LVL     4
`define F_SLEW        0
`define F_LO          7:0
`define F_HI          15:8
`define F_MAG         14:0
`define F_MSB         15

`define SLEW_NORMAL   1'b0
`define SLEW_FAST     1'b1
`define SLEW_FALL_CYC 3'h4
`define ZERO16        16'h0000

`endif

// ==== core/alu_pkg.sv ====
// Purpose: shared types for the microcore instruction group
// Assumes: widths from alu_params.svh
// Notes: none
`include "alu_params.svh"
package alu_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SUB  = 3'b001,
    OP_SUBI = 3'b010,
    OP_SWAP = 3'b011,
    OP_MAGNITUDE_TO_TWOS_FORM_OP = 3'b100,
    OP_SLEW = 3'b101,
    OP_SRB  = 3'b110
  } op_t;

  typedef struct packed {
    logic zero_result_flag;
    logic negative_result_flag;
    logic unsigned_low_wrap_flag;
    logic unsigned_high_wrap_flag;
    logic signed_low_wrap_flag;
    logic signed_high_wrap_flag;
  } flags_t;

  typedef struct packed {
    logic [`DATA_W-1:0] res;
    flags_t             flg;
  } sub_res_t;

  typedef struct packed {
    logic [`NREG-1:0][`DATA_W-1:0] regs;
    logic [3:0][`DATA_W-1:0]       grant;
    logic [`DATA_W-1:0]            status;
    flags_t                        flags;
    logic                          sign;
    logic                          slew_select;
    logic [`DATA_W-1:0]            cfg_rdata;
    logic [`DATA_W-1:0]            rd_data;
  } core_state_t;

  typedef struct packed {
    logic       fast;
    logic [2:0] cnt;
  } slew_state_t;

endpackage : alu_pkg

// ==== core/slew_ramp.sv ====
// Purpose: turns the requested slew mode into the effective mode with its latency
// Assumes: req_i comes from a register on sys_clk
// Notes: rise one cycle, fall four cycles after the request register changes
`timescale 1ns/1ps
`include "alu_params.svh"
module slew_ramp (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic req_i,
  output logic      fast_o
);

  alu_pkg::slew_state_t q;
  alu_pkg::slew_state_t d;

  always_comb begin
    d = q;
    if (req_i == q.fast) begin
      d.cnt = 3'h0;
    end else if (req_i) begin
      d.fast = `SLEW_FAST; // RULE_04
      d.cnt  = 3'h0;
    end else if (q.cnt == `SLEW_FALL_CYC - 3'h1) begin
      // driver needs time to discharge, so slowing down lags
      d.fast = `SLEW_NORMAL; // RULE_05
      d.cnt  = 3'h0;
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q.fast <= `SLEW_NORMAL; // RULE_03
      q.cnt  <= 3'h0;
    end else begin
      q <= d;
    end
  end

  assign fast_o = q.fast;

endmodule : slew_ramp

// ==== core/microcore_alu_slew_status_ops.sv ====
// Purpose: execute slew-mode, status-bit, subtract, swap and conversion instructions
// Assumes: all inputs come from logic on sys_clk, so none is synchronised
// Notes: instruction writes win over the external register write port
`timescale 1ns/1ps
`include "alu_params.svh"
module microcore_alu_slew_status_ops (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 instr_valid_i,
  input  wire logic [`DATA_W-1:0]   instr_i,
  input  wire logic                 cfg_wr_i,
  input  wire logic                 cfg_rd_i,
  input  wire logic [`CFG_AW-1:0]   cfg_addr_i,
  input  wire logic [`DATA_W-1:0]   cfg_wdata_i,
  output logic      [`DATA_W-1:0]   cfg_rdata_o,
  input  wire logic                 ext_wr_i,
  input  wire logic [`SEL_W-1:0]    ext_sel_i,
  input  wire logic [`DATA_W-1:0]   ext_data_i,
  input  wire logic [`SEL_W-1:0]    rd_sel_i,
  output logic      [`DATA_W-1:0]   rd_data_o,
  input  wire logic                 cs_load_i,
  input  wire logic                 cs_value_i,
  output logic      [`DATA_W-1:0]   status_o,
  output alu_pkg::flags_t           flags_o,
  output logic                      cs_flag_o,
  output logic                      slew_select_o,
  output logic                      slew_fast_o
);

  alu_pkg::core_state_t q;
  alu_pkg::core_state_t d;
  alu_pkg::op_t         op;
  alu_pkg::sub_res_t    sres;
  logic                 granted;
  logic [`DATA_W-1:0]   src_a;
  logic [`DATA_W-1:0]   src_b;
  logic [`DATA_W-1:0]   neg_mag;

  function automatic alu_pkg::op_t decode(input logic [`DATA_W-1:0] w);
    alu_pkg::op_t o;
    o = alu_pkg::OP_NONE;
    if (w[`F_OPC6] == `OPC_SUB) begin
      o = alu_pkg::OP_SUB; // RULE_11
    end else if (w[`F_OPC6] == `OPC_SUBI) begin
      o = alu_pkg::OP_SUBI; // RULE_13
    end else if (w[`F_OPC13] == `OPC_SWAP) begin
      o = alu_pkg::OP_SWAP; // RULE_15
    end else if (w[`F_OPC13] == `OPC_MAGNITUDE_TO_TWOS_FORM_OP) begin
      o = alu_pkg::OP_MAGNITUDE_TO_TWOS_FORM_OP; // RULE_18
    end else if (w[`F_OPC15] == `OPC_SLEW) begin
      o = alu_pkg::OP_SLEW; // RULE_06
    end else if (w[`F_OPC11] == `OPC_SRB) begin
      o = alu_pkg::OP_SRB; // RULE_08
    end
    return o;
  endfunction : decode

  // shared by both subtract forms so their flags cannot drift apart
  function automatic alu_pkg::sub_res_t sub_calc(input logic [`DATA_W-1:0] a,
                                                 input logic [`DATA_W-1:0] b);
    alu_pkg::sub_res_t s;
    logic [`DATA_W:0]  w;
    w = {1'b0, a} - {1'b0, b};
    s.res                         = w[`DATA_W-1:0];
    s.flg.zero_result_flag        = (w[`DATA_W-1:0] == `ZERO16); // RULE_10
    s.flg.negative_result_flag    = w[`F_MSB];
    s.flg.unsigned_low_wrap_flag  = w[`DATA_W];
    // a difference of unsigned values can never exceed the top
    s.flg.unsigned_high_wrap_flag = 1'b0;
    s.flg.signed_low_wrap_flag    = a[`F_MSB] & ~b[`F_MSB] & ~w[`F_MSB];
    s.flg.signed_high_wrap_flag   = ~a[`F_MSB] & b[`F_MSB] & w[`F_MSB];
    return s;
  endfunction : sub_calc

  always_comb begin
    op      = instr_valid_i ? decode(instr_i) : alu_pkg::OP_NONE;
    granted = |((q.grant[0] | q.grant[1] | q.grant[2] | q.grant[3]) & `GRANT_MASK);
    src_a   = q.regs[instr_i[`F_OP1]]; // RULE_20
    src_b   = (op == alu_pkg::OP_SUBI) ? {12'h000, instr_i[`F_IMM]} // RULE_12
                                       : q.regs[instr_i[`F_OP2]];
    sres    = sub_calc(src_a, src_b);
    neg_mag = {1'b1, 15'(~src_a[`F_MAG] + 15'h0001)};
  end

  always_comb begin
    d = q;
    if (ext_wr_i) begin
      d.regs[ext_sel_i] = ext_data_i;
    end
    if (cs_load_i) begin
      d.sign = cs_value_i; // RULE_19
    end
    if (cfg_wr_i) begin
      case (cfg_addr_i)
        `GRANT_A_ADDR: d.grant[0] = cfg_wdata_i;
        `GRANT_B_ADDR: d.grant[1] = cfg_wdata_i;
        `GRANT_C_ADDR: d.grant[2] = cfg_wdata_i;
        `GRANT_D_ADDR: d.grant[3] = cfg_wdata_i;
        default:       d.grant    = q.grant;
      endcase
    end
    if (cfg_rd_i) begin
      case (cfg_addr_i)
        `GRANT_A_ADDR: d.cfg_rdata = q.grant[0];
        `GRANT_B_ADDR: d.cfg_rdata = q.grant[1];
        `GRANT_C_ADDR: d.cfg_rdata = q.grant[2];
        `GRANT_D_ADDR: d.cfg_rdata = q.grant[3];
        default:       d.cfg_rdata = `ZERO16;
      endcase
    end
    d.rd_data = q.regs[rd_sel_i];
    case (op)
      alu_pkg::OP_SUB: begin
        d.regs[instr_i[`F_RES_SUB]] = sres.res; // RULE_09
        d.flags                     = sres.flg; // RULE_10
      end
      alu_pkg::OP_SUBI: begin
        d.regs[instr_i[`F_RES_SUBI]] = sres.res; // RULE_12
        d.flags                      = sres.flg; // RULE_10
      end
      alu_pkg::OP_SWAP: begin
        d.regs[instr_i[`F_OP1]] = {src_a[`F_LO], src_a[`F_HI]}; // RULE_14
      end
      alu_pkg::OP_MAGNITUDE_TO_TWOS_FORM_OP: begin
        if (q.sign) begin
          d.regs[instr_i[`F_OP1]] = neg_mag; // RULE_17
        end else begin
          d.regs[instr_i[`F_OP1]] = {1'b0, src_a[`F_MAG]}; // RULE_16
        end
      end
      alu_pkg::OP_SLEW: begin
        if (granted) begin
          d.slew_select = instr_i[`F_SLEW]; // RULE_01 RULE_02
        end
      end
      alu_pkg::OP_SRB: begin
        d.status[instr_i[`F_SRB_IDX]] = instr_i[`F_SRB_LVL]; // RULE_07
      end
      default: begin
        d.flags = q.flags;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q             <= '0;
      q.slew_select <= `SLEW_NORMAL; // RULE_03
    end else begin
      q <= d; // RULE_20
    end
  end

  slew_ramp u_slew_ramp (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .req_i     (q.slew_select),
    .fast_o    (slew_fast_o)
  );

  assign cfg_rdata_o   = q.cfg_rdata;
  assign rd_data_o     = q.rd_data;
  assign status_o      = q.status;
  assign flags_o       = q.flags;
  assign cs_flag_o     = q.sign;
  assign slew_select_o = q.slew_select;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  slew_take_a: assert property (op == alu_pkg::OP_SLEW && granted // RULE_01
    |=> q.slew_select == $past(instr_i[`F_SLEW]))
    else $error("slew select did not follow granted instruction");

  slew_deny_a: assert property (op == alu_pkg::OP_SLEW && !granted // RULE_02
    |=> $stable(q.slew_select))
    else $error("slew select changed without drive right");

  slew_rise_a: assert property ($rose(q.slew_select) |-> !slew_fast_o ##1 slew_fast_o) // RULE_04
    else $error("fast slew not effective one cycle after request");

  slew_fall_a: assert property ($fell(q.slew_select) && slew_fast_o // RULE_05
    ##1 !q.slew_select [*3] |-> slew_fast_o ##1 !slew_fast_o)
    else $error("normal slew not effective four cycles after request");

  srb_write_a: assert property (op == alu_pkg::OP_SRB // RULE_07
    |=> q.status[$past(instr_i[`F_SRB_IDX])] == $past(instr_i[`F_SRB_LVL]))
    else $error("status bit not written with level");

  sub_result_a: assert property (op == alu_pkg::OP_SUB // RULE_09
    |=> q.regs[$past(instr_i[`F_RES_SUB])]
        == 16'($past(q.regs[instr_i[`F_OP1]]) - $past(q.regs[instr_i[`F_OP2]])))
    else $error("register difference wrong");

  sub_borrow_a: assert property (op == alu_pkg::OP_SUB // RULE_10
    |=> q.flags.unsigned_low_wrap_flag
        == ($past(q.regs[instr_i[`F_OP1]]) < $past(q.regs[instr_i[`F_OP2]])))
    else $error("unsigned underflow flag wrong");

  subi_zero_a: assert property (op == alu_pkg::OP_SUBI // RULE_12
    |=> q.flags.zero_result_flag == (q.regs[$past(instr_i[`F_RES_SUBI])] == `ZERO16))
    else $error("zero flag disagrees with immediate difference");

  swap_bytes_a: assert property (op == alu_pkg::OP_SWAP // RULE_14
    |=> q.regs[$past(instr_i[`F_OP1])]
        == {$past(src_a[`F_LO]), $past(src_a[`F_HI])})
    else $error("bytes not swapped");

  magnitude_to_twos_form_op_msb_a: assert property (op == alu_pkg::OP_MAGNITUDE_TO_TWOS_FORM_OP // RULE_16
    |=> q.regs[$past(instr_i[`F_OP1])][`F_MSB] == $past(q.sign))
    else $error("conversion msb does not match sign flag");

endmodule : microcore_alu_slew_status_ops

// ==== sim/predriver_model.sv ====
// Purpose: pre-driver stand-in that turns the effective slew mode into a rate code
// Assumes: four rate codes, the highest one is FAST_RATE
// Notes: the programmed rate comes straight from the bench
`timescale 1ns/1ps
module predriver_model #(
  parameter logic [1:0] FAST_RATE = 2'h3
) (
  input  wire logic       slew_fast_i,
  input  wire logic [1:0] prog_rate_i,
  output logic      [1:0] rate_o
);
  // forced mode overrides whatever rate is programmed
  assign rate_o = slew_fast_i ? FAST_RATE : prog_rate_i;
endmodule : predriver_model

// ==== sim/microcore_alu_slew_status_ops_tb_top.sv ====
// Purpose: random and corner tests of the slew, status-bit and arithmetic group
// Assumes: results visible just after the edge that takes the instruction
// Notes: calc registers are loaded and observed through the ext and rd ports
`timescale 1ns/1ps
`include "alu_params.svh"
module microcore_alu_slew_status_ops_tb_top;
  logic               sys_clk_i = 1'b0;
  logic               reset_n_i = 1'b0;
  logic               instr_valid_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
  logic               ext_wr_i = 1'b0, cs_load_i = 1'b0, cs_value_i = 1'b0;
  logic [15:0]        instr_i = '0, cfg_wdata_i = '0, ext_data_i = '0, st, a, b, e, v;
  logic [8:0]         cfg_addr_i = '0;
  logic [2:0]         ext_sel_i = '0, rd_sel_i = '0, s1, s2, d;
  logic [3:0]         im, idx;
  logic [1:0]         rate;
  logic [15:0]        cfg_rdata_o, rd_data_o, status_o;
  alu_pkg::flags_t    flags_o, f;
  logic               cs_flag_o, slew_select_o, slew_fast_o, c;
  int                 fails = 0;
  int                 n_tests = 0;

  microcore_alu_slew_status_ops dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .ext_wr_i(ext_wr_i), .ext_sel_i(ext_sel_i),
    .ext_data_i(ext_data_i), .rd_sel_i(rd_sel_i), .rd_data_o(rd_data_o),
    .cs_load_i(cs_load_i), .cs_value_i(cs_value_i), .status_o(status_o),
    .flags_o(flags_o), .cs_flag_o(cs_flag_o), .slew_select_o(slew_select_o),
    .slew_fast_o(slew_fast_o));
  predriver_model pdrv (.slew_fast_i(slew_fast_o), .prog_rate_i(2'h1), .rate_o(rate));

  always #2 sys_clk_i = ~sys_clk_i;

  task automatic chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk_word
  task automatic chk_flags(input string nm, input alu_pkg::flags_t ex,
                           input alu_pkg::flags_t got);
    n_tests++;
    if (got !== ex) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, ex, got);
    end
  endtask : chk_flags
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // every bus task except rd_reg raises on one edge and drops on the edge that takes it
  task automatic exec(input logic [15:0] w);
    @(posedge sys_clk_i); instr_valid_i <= 1'b1; instr_i <= w;
    @(posedge sys_clk_i); instr_valid_i <= 1'b0; #1;
  endtask : exec
  task automatic wr_reg(input logic [2:0] s, input logic [15:0] x);
    @(posedge sys_clk_i); ext_wr_i <= 1'b1; ext_sel_i <= s; ext_data_i <= x;
    @(posedge sys_clk_i); ext_wr_i <= 1'b0; #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] s, output logic [15:0] x);
    @(posedge sys_clk_i); rd_sel_i <= s;
    @(posedge sys_clk_i); #1 x = rd_data_o;
  endtask : rd_reg
  task automatic cfg(input logic w, input logic [8:0] ad, input logic [15:0] x);
    @(posedge sys_clk_i); cfg_wr_i <= w; cfg_rd_i <= ~w; cfg_addr_i <= ad; cfg_wdata_i <= x;
    @(posedge sys_clk_i); cfg_wr_i <= 1'b0; cfg_rd_i <= 1'b0; #1;
  endtask : cfg
  function automatic alu_pkg::flags_t exp_flags(input logic [15:0] p, input logic [15:0] q);
    logic [15:0] r;
    r = p - q;
    return '{r == 16'h0000, r[15], p < q, 1'b0, p[15] & ~q[15] & ~r[15],
             ~p[15] & q[15] & r[15]};
  endfunction : exp_flags

  initial begin
    repeat (30000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(18147));
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    #1 chk_word("slew after reset", 16'h0000, {slew_select_o, slew_fast_o});
    chk_word("status after reset", 16'h0000, status_o);
    for (int i = 0; i < 5; i++) begin
      cfg(1'b0, 9'h184 + 9'(i), 16'h0000);
      chk_word("grant or unmapped read", 16'h0000, cfg_rdata_o);
    end
    exec({`OPC_SLEW, 1'b1});
    chk_word("slew without grant", 16'h0000, {slew_select_o, slew_fast_o});
    cfg(1'b1, `GRANT_C_ADDR, 16'h0001);
    cfg(1'b0, `GRANT_C_ADDR, 16'h0000);
    chk_word("grant readback", 16'h0001, cfg_rdata_o);
    exec({`OPC_SLEW, 1'b1});
    chk_word("slew fast request", 16'h0002, {slew_select_o, slew_fast_o});
    @(posedge sys_clk_i); #1 chk_word("slew fast effect", 16'h0007, {rate, slew_fast_o});
    exec({`OPC_SLEW, 1'b0});
    for (int i = 1; i <= 4; i++) begin
      chk_word("slew fall wait", {15'h0, i <= 4}, {slew_select_o, slew_fast_o});
      @(posedge sys_clk_i); #1;
    end
    chk_word("slew normal rate", 16'h0001, {slew_fast_o, rate});
    $display("test slew done");
    st = 16'h0000;
    for (int i = 0; i < 40; i++) begin
      idx = (i < 2) ? 4'(i * 15) : 4'($urandom);
      c = (i < 2) ? 1'b1 : 1'($urandom);
      exec({`OPC_SRB, c, idx});
      st[idx] = c;
      chk_word("status", st, status_o);
    end
    $display("test status bits done");
    for (int i = 0; i < 30; i++) begin
      a = (i == 0) ? 16'h8000 : (i == 3) ? 16'h0000 : 16'($urandom);
      b = (i == 1) ? a : (i == 3) ? 16'h8000 : 16'($urandom);
      s1 = 3'($urandom); s2 = s1 + 3'h1; d = 3'($urandom); im = 4'($urandom);
      wr_reg(s1, a);
      wr_reg(s2, b);
      if (i % 2) begin
        exec({`OPC_SUB, 1'b0, d, s2, s1});
      end else begin
        b = {12'h000, im};
        exec({`OPC_SUBI, d, im, s1});
      end
      f = exp_flags(a, b);
      chk_flags("flags", f, flags_o);
      rd_reg(d, v);
      chk_word("difference", a - b, v);
    end
    $display("test subtract done");
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 16'h8000 : 16'($urandom);
      c = 1'(i);
      wr_reg(3'(i), a);
      exec({`OPC_SWAP, 3'(i)});
      rd_reg(3'(i), v);
      chk_word("swap", {a[7:0], a[15:8]}, v);
      @(posedge sys_clk_i); cs_load_i <= 1'b1; cs_value_i <= c;
      @(posedge sys_clk_i); cs_load_i <= 1'b0; #1;
      chk_word("sign flag", {15'h0, c}, {15'h0, cs_flag_o});
      exec({`OPC_MAGNITUDE_TO_TWOS_FORM_OP, 3'(i)});
      rd_reg(3'(i), e);
      chk_word("twos form", c ? {1'b1, 15'(~v[14:0] + 15'h1)} : {1'b0, v[14:0]}, e);
      chk_flags("flags kept", f, flags_o);
    end
    $display("test swap and conversion done");
    tally_and_finish();
  end
endmodule : microcore_alu_slew_status_ops_tb_top
